/* shared/bssc_params.svh */
// Constants for the burst SRAM synchronous control block
// What this block does
// - Sample address, write data, strobes, select, byte writes and step on each rising edge.
// - Latch the sixteen-bit word address when the controller strobe is low, or the processor strobe is low with chip select low.
// - Load the two low address bits into the burst counter on a controller strobe or a chip-selected processor strobe.
// - Both strobes low with chip select low means a processor-strobe cycle; controller strobe is disregarded.
// - Processor strobe has no effect at all while chip select is high.
// - Upper byte write low writes upper data byte and upper parity bit.
// - Lower byte write low writes lower data byte and lower parity bit.
// - Processor strobe with chip select low suppresses both byte writes that cycle.
// - With chip select high, processor strobe does not suppress byte writes.
// - Burst step low advances the two-bit wraparound burst counter by one.
// - Burst stepping order is chosen at build time: linear or interleaved.
// - Burst step is ignored when a strobe is low with chip select low.
// - With chip select high, processor strobe does not block burst step.
// - Chip select high with controller strobe low deselects; no access.
// - Chip select low with a strobe low captures address and starts access.
// - Interleaved burst address is start value XOR step count.
// - Linear burst address is start value plus step count, modulo four.
// - A half's data and parity lines float when its byte write is sampled low.
// - Controller-strobe write completes in one cycle with same-edge address and data.
`ifndef BSSC_PARAMS_SVH
`define BSSC_PARAMS_SVH
`define BSSC_ADDR_W 16
`define BSSC_DATA_W 16
`define BSSC_PAR_W 2
`define BSSC_BURST_W 2
`define BSSC_ADDR_RST 16'h0000
`define BSSC_BURST_RST 2'h0
`endif

/* shared/bssc_pkg.sv */
// Types shared by the burst SRAM synchronous control block
package bssc_pkg;
  typedef enum logic {BSSC_ORDER_INTERLEAVED, BSSC_ORDER_LINEAR} bssc_order_t;
endpackage

/* hw/bssc_ctrl.sv */
// Synchronous control logic of a burst cache SRAM: address, burst counter, writes, drive
`timescale 1ns/1ns
`include "bssc_params.svh"
module bssc_ctrl import bssc_pkg::*; #(
  parameter bssc_order_t BURST_ORDER = BSSC_ORDER_INTERLEAVED
) (
  input wire logic i_sys_clk, // System clock, 100 MHz
  input wire logic i_reset, // Async reset, active high
  input wire logic [`BSSC_ADDR_W-1:0] i_word_address, // Word address
  input wire logic [`BSSC_DATA_W-1:0] i_data_lines, // Data lines, incoming level
  input wire logic [`BSSC_PAR_W-1:0] i_parity_lines, // Parity lines, incoming level
  input wire logic i_processor_address_strobe_n, // Processor address strobe
  input wire logic i_controller_address_strobe_n, // Controller address strobe
  input wire logic i_chip_select_n, // Chip select
  input wire logic i_upper_byte_write_n, // Upper byte write
  input wire logic i_lower_byte_write_n, // Lower byte write
  input wire logic i_burst_step_n, // Burst advance
  input wire logic i_output_drive_n, // Output drive, asynchronous
  input wire logic [`BSSC_DATA_W+`BSSC_PAR_W-1:0] i_array_rdata, // Array read word
  output logic [`BSSC_ADDR_W-1:0] o_array_addr, // Array word address
  output logic [`BSSC_DATA_W+`BSSC_PAR_W-1:0] o_array_wdata, // Array write word
  output logic o_array_we_upper, // Write upper half this cycle
  output logic o_array_we_lower, // Write lower half this cycle
  output logic [`BSSC_DATA_W-1:0] o_data_lines, // Data lines, driven level
  output logic [`BSSC_PAR_W-1:0] o_parity_lines, // Parity lines, driven level
  output logic o_lines_oe_upper, // Drive upper data and parity lines
  output logic o_lines_oe_lower // Drive lower data and parity lines
);
  // Pins are synchronous to i_sys_clk; only the output drive pin and i_reset are asynchronous
  logic drive_n_meta_reg;
  logic drive_n_sync_reg;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      drive_n_meta_reg <= 1'b1;
      drive_n_sync_reg <= 1'b1;
    end else begin
      drive_n_meta_reg <= i_output_drive_n;
      drive_n_sync_reg <= drive_n_meta_reg;
    end
  end

  // Decode of the pins as sampled at this edge
  logic proc_strobe;
  logic ctrl_strobe;
  logic addr_load;
  logic new_access;
  logic deselect;
  logic step;
  logic wr_upper;
  logic wr_lower;
  assign proc_strobe = !i_processor_address_strobe_n && !i_chip_select_n;
  assign ctrl_strobe = !i_controller_address_strobe_n && !proc_strobe;
  assign addr_load = proc_strobe || ctrl_strobe;
  assign new_access = addr_load && !i_chip_select_n;
  assign deselect = i_chip_select_n && !i_controller_address_strobe_n;
  // Loading wins over stepping; with select high a processor strobe never blocks it
  assign step = !i_burst_step_n && !new_access;
  // Processor-strobe cycle leaves the first clock to tag compare, so no write then
  assign wr_upper = !i_upper_byte_write_n && !proc_strobe && !deselect;
  assign wr_lower = !i_lower_byte_write_n && !proc_strobe && !deselect;

  // Address register and burst counter
  logic [`BSSC_ADDR_W-1:0] addr_reg;
  logic [`BSSC_BURST_W-1:0] start_reg;
  logic [`BSSC_BURST_W-1:0] count_reg;
  logic [`BSSC_ADDR_W-1:0] addr_next;
  logic [`BSSC_BURST_W-1:0] start_next;
  logic [`BSSC_BURST_W-1:0] count_next;
  logic [`BSSC_BURST_W-1:0] burst_next;

  always_comb begin
    addr_next = addr_reg;
    start_next = start_reg;
    count_next = count_reg;
    if (addr_load) begin
      addr_next = i_word_address;
      start_next = i_word_address[`BSSC_BURST_W-1:0];
      count_next = `BSSC_BURST_RST;
    end else if (step) begin
      count_next = count_reg + 2'h1;
    end
    if (BURST_ORDER == BSSC_ORDER_LINEAR) begin
      burst_next = start_next + count_next;
    end else begin
      burst_next = start_next ^ count_next;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      addr_reg <= `BSSC_ADDR_RST;
      start_reg <= `BSSC_BURST_RST;
      count_reg <= `BSSC_BURST_RST;
    end else begin
      addr_reg <= addr_next;
      start_reg <= start_next;
      count_reg <= count_next;
    end
  end

  // Array side: address, data and strobes of the access begun at this edge
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_array_addr <= `BSSC_ADDR_RST;
      o_array_wdata <= '0;
      o_array_we_upper <= 1'b0;
      o_array_we_lower <= 1'b0;
    end else begin
      o_array_addr <= {addr_next[`BSSC_ADDR_W-1:`BSSC_BURST_W], burst_next};
      o_array_wdata <= {i_parity_lines, i_data_lines};
      o_array_we_upper <= wr_upper;
      o_array_we_lower <= wr_lower;
    end
  end

  // Read drive: selected by a chip-selected strobe, dropped on deselect
  logic selected_reg;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      selected_reg <= 1'b0;
    end else if (new_access) begin
      selected_reg <= 1'b1;
    end else if (deselect) begin
      selected_reg <= 1'b0;
    end
  end

  // Enables come from the edge's own sample so a written half never fights the writer
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_lines_oe_upper <= 1'b0;
      o_lines_oe_lower <= 1'b0;
      o_data_lines <= '0;
      o_parity_lines <= '0;
    end else begin
      o_lines_oe_upper <= !drive_n_sync_reg && selected_reg && !new_access && !deselect
                          && i_upper_byte_write_n;
      o_lines_oe_lower <= !drive_n_sync_reg && selected_reg && !new_access && !deselect
                          && i_lower_byte_write_n;
      o_data_lines <= i_array_rdata[`BSSC_DATA_W-1:0];
      o_parity_lines <= i_array_rdata[`BSSC_DATA_W+`BSSC_PAR_W-1:`BSSC_DATA_W];
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_proc_blocks_write: assert property (
    !i_processor_address_strobe_n && !i_chip_select_n |=> !o_array_we_upper && !o_array_we_lower)
    else $error("write taken in a processor-strobe cycle");
  chk_upper_write_taken: assert property (
    !i_upper_byte_write_n && i_processor_address_strobe_n && !i_chip_select_n |=> o_array_we_upper)
    else $error("upper byte write lost");
  chk_lower_write_taken: assert property (
    !i_lower_byte_write_n && i_processor_address_strobe_n && !i_chip_select_n |=> o_array_we_lower)
    else $error("lower byte write lost");
  chk_strobe_ignored_deselected: assert property (
    !i_processor_address_strobe_n && i_chip_select_n && i_controller_address_strobe_n
    && i_burst_step_n |=> $stable(addr_reg) && $stable(count_reg))
    else $error("processor strobe acted while deselected");
  chk_addr_loaded: assert property (
    !i_chip_select_n && !i_controller_address_strobe_n
    |=> o_array_addr[15:2] == $past(i_word_address[15:2]) && count_reg == 2'h0)
    else $error("address not captured on strobe");
  chk_ctrl_write_same: assert property (
    !i_chip_select_n && !i_controller_address_strobe_n && i_processor_address_strobe_n
    && !i_lower_byte_write_n |=> o_array_we_lower && o_array_addr == $past(i_word_address)
    && o_array_wdata == $past({i_parity_lines, i_data_lines}))
    else $error("controller write not single-cycle");
  chk_step_blocked: assert property (
    !i_chip_select_n && !i_processor_address_strobe_n && !i_burst_step_n
    |=> count_reg == 2'h0)
    else $error("burst stepped during load");
  chk_step_advances: assert property (
    i_processor_address_strobe_n && i_controller_address_strobe_n && !i_burst_step_n
    |=> count_reg == $past(count_reg) + 2'h1 && $stable(start_reg))
    else $error("burst counter failed to advance");
  chk_burst_order: assert property (
    i_processor_address_strobe_n && i_controller_address_strobe_n
    |=> o_array_addr[1:0] == ((BURST_ORDER == BSSC_ORDER_LINEAR) ? start_reg + count_reg
                              : start_reg ^ count_reg))
    else $error("burst address out of order");
  chk_float_on_write: assert property (
    !i_upper_byte_write_n |=> !o_lines_oe_upper)
    else $error("upper lines driven during write");
  chk_deselect_quiet: assert property (
    i_chip_select_n && !i_controller_address_strobe_n
    |=> !o_array_we_upper && !o_array_we_lower ##1 !o_lines_oe_upper && !o_lines_oe_lower)
    else $error("access while deselected");

  // Further checks on loading, stepping, writes and line drive

  chk_both_strobes_proc: assert property (
    !i_processor_address_strobe_n && !i_controller_address_strobe_n && !i_chip_select_n
    |=> addr_reg == $past(i_word_address) && !o_array_we_lower)
    else $error("both strobes not treated as processor cycle");

  chk_start_loaded: assert property (
    addr_load
    |=> start_reg == $past(i_word_address[1:0]) && count_reg == 2'h0)
    else $error("burst start not loaded");

  chk_ctrl_loads_deselected: assert property (
    i_chip_select_n && !i_controller_address_strobe_n
    |=> addr_reg == $past(i_word_address))
    else $error("controller strobe did not latch address");

  chk_lower_cs_high: assert property (
    i_chip_select_n && i_controller_address_strobe_n && !i_lower_byte_write_n
    |=> o_array_we_lower)
    else $error("lower write lost with select high");

  chk_upper_cs_high: assert property (
    i_chip_select_n && i_controller_address_strobe_n && !i_upper_byte_write_n
    |=> o_array_we_upper)
    else $error("upper write lost with select high");

  chk_step_cs_high: assert property (
    i_chip_select_n && i_controller_address_strobe_n && !i_burst_step_n
    |=> count_reg == $past(count_reg) + 2'h1)
    else $error("step blocked with select high");

  chk_step_blocked_ctrl: assert property (
    !i_chip_select_n && !i_controller_address_strobe_n && !i_burst_step_n
    |=> count_reg == 2'h0)
    else $error("burst stepped during controller load");

  chk_idle_holds: assert property (
    i_processor_address_strobe_n && i_controller_address_strobe_n && i_burst_step_n
    |=> $stable(count_reg) && $stable(addr_reg))
    else $error("state changed without request");

  chk_wdata_sampled: assert property (
    1'b1
    |=> o_array_wdata[17:16] == $past(i_parity_lines) && o_array_wdata[15:0] == $past(i_data_lines))
    else $error("write data not sampled at the edge");

  chk_upper_we_source: assert property (
    o_array_we_upper
    |-> !$past(i_upper_byte_write_n))
    else $error("upper write without request");

  chk_lower_we_source: assert property (
    o_array_we_lower
    |-> !$past(i_lower_byte_write_n))
    else $error("lower write without request");

  chk_addr_upper_map: assert property (
    1'b1
    |-> o_array_addr[15:2] == addr_reg[15:2])
    else $error("array address upper bits wrong");

  chk_lower_float: assert property (
    !i_lower_byte_write_n
    |=> !o_lines_oe_lower)
    else $error("lower lines driven during write");

  chk_oe_after_strobe: assert property (
    new_access
    |=> !o_lines_oe_upper && !o_lines_oe_lower && selected_reg)
    else $error("new access not started");

  chk_deselect_clears: assert property (
    deselect
    |=> !selected_reg)
    else $error("deselect did not drop selection");

  chk_oe_needs_select: assert property (
    o_lines_oe_lower || o_lines_oe_upper
    |-> $past(selected_reg) && !$past(drive_n_sync_reg))
    else $error("lines driven while not selected");

  chk_ctrl_write_upper: assert property (
    !i_chip_select_n && !i_controller_address_strobe_n && i_processor_address_strobe_n
    && !i_upper_byte_write_n |=> o_array_we_upper && o_array_addr == $past(i_word_address))
    else $error("controller upper write not single-cycle");

  chk_load_beats_step: assert property (
    addr_load && !i_burst_step_n
    |=> count_reg == 2'h0)
    else $error("step won over load");

  chk_counter_wraps: assert property (
    step && count_reg == 2'h3
    |=> count_reg == 2'h0)
    else $error("burst counter did not wrap");

  chk_proc_cs_high_inert: assert property (
    !i_processor_address_strobe_n && i_chip_select_n && i_controller_address_strobe_n
    |=> selected_reg == $past(selected_reg))
    else $error("processor strobe selected while deselected");

  cov_deselect: cover property (deselect ##1 !o_lines_oe_lower);
  cov_proc_then_write: cover property (
    !i_processor_address_strobe_n && !i_chip_select_n ##1 !i_upper_byte_write_n);
  cov_ctrl_write: cover property (
    !i_controller_address_strobe_n && !i_chip_select_n && !i_lower_byte_write_n);
  cov_full_burst: cover property (
    addr_load ##1 step ##1 step ##1 step);
  cov_read_drive: cover property (o_lines_oe_upper && o_lines_oe_lower);

endmodule // bssc_ctrl

/* verification/bssc_array_model.sv */
// Behavioural memory array on the far side of the block
`timescale 1ns/1ns
`include "bssc_params.svh"
module bssc_array_model (
  input wire logic i_sys_clk, // Clock
  input wire logic [`BSSC_ADDR_W-1:0] i_addr, // Array word address
  input wire logic [`BSSC_DATA_W+`BSSC_PAR_W-1:0] i_wdata, // Write word
  input wire logic i_we_upper, // Write upper half
  input wire logic i_we_lower, // Write lower half
  output logic [`BSSC_DATA_W+`BSSC_PAR_W-1:0] o_rdata // Read word
);
  // Only 256 words kept: upper address bits alias, enough for short tests
  logic [17:0] mem_reg [0:255];
  always_ff @(posedge i_sys_clk) begin
    if (i_we_upper) begin
      mem_reg[i_addr[7:0]][17] <= i_wdata[17];
      mem_reg[i_addr[7:0]][15:8] <= i_wdata[15:8];
    end
    if (i_we_lower) begin
      mem_reg[i_addr[7:0]][16] <= i_wdata[16];
      mem_reg[i_addr[7:0]][7:0] <= i_wdata[7:0];
    end
  end
  assign o_rdata = mem_reg[i_addr[7:0]];
endmodule // bssc_array_model

/* verification/tb.sv */
// Testbench for the burst SRAM control block: writes, strobes and burst orders
`timescale 1ns/1ns
`include "bssc_params.svh"
module tb import bssc_pkg::*; ;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic sel_n = 1'b1, pstb_n = 1'b1, cstb_n = 1'b1, wh_n = 1'b1, wl_n = 1'b1, step_n = 1'b1;
  logic [15:0] addr = 16'h0000, dq = 16'h0000;
  logic [1:0] dp = 2'h0;
  logic drv_n = 1'b0;
  logic [15:0] a_i, a_l, dqo_i, dqo_l;
  logic [17:0] wd_i, wd_l, rd_i, rd_l;
  logic [1:0] dpo_i, dpo_l;
  logic weu, wel, weu_l, wel_l, oeu, oel, oeu_l, oel_l;
  int n_mismatch = 0;
  int total_checks = 0;
  bssc_ctrl #(.BURST_ORDER(BSSC_ORDER_INTERLEAVED)) i_bssc_ctrl (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_word_address(addr), .i_data_lines(dq), .i_parity_lines(dp),
    .i_processor_address_strobe_n(pstb_n), .i_controller_address_strobe_n(cstb_n),
    .i_chip_select_n(sel_n), .i_upper_byte_write_n(wh_n), .i_lower_byte_write_n(wl_n),
    .i_burst_step_n(step_n), .i_output_drive_n(drv_n), .i_array_rdata(rd_i),
    .o_array_addr(a_i), .o_array_wdata(wd_i), .o_array_we_upper(weu), .o_array_we_lower(wel),
    .o_data_lines(dqo_i), .o_parity_lines(dpo_i), .o_lines_oe_upper(oeu), .o_lines_oe_lower(oel));
  bssc_ctrl #(.BURST_ORDER(BSSC_ORDER_LINEAR)) i_bssc_ctrl_lin (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_word_address(addr), .i_data_lines(dq), .i_parity_lines(dp),
    .i_processor_address_strobe_n(pstb_n), .i_controller_address_strobe_n(cstb_n),
    .i_chip_select_n(sel_n), .i_upper_byte_write_n(wh_n), .i_lower_byte_write_n(wl_n),
    .i_burst_step_n(step_n), .i_output_drive_n(drv_n), .i_array_rdata(rd_l),
    .o_array_addr(a_l), .o_array_wdata(wd_l), .o_array_we_upper(weu_l),
    .o_array_we_lower(wel_l), .o_data_lines(dqo_l), .o_parity_lines(dpo_l),
    .o_lines_oe_upper(oeu_l), .o_lines_oe_lower(oel_l));
  bssc_array_model i_bssc_array_model (.i_sys_clk(i_sys_clk), .i_addr(a_i), .i_wdata(wd_i),
    .i_we_upper(weu), .i_we_lower(wel), .o_rdata(rd_i));
  bssc_array_model i_bssc_array_model_lin (.i_sys_clk(i_sys_clk), .i_addr(a_l),
    .i_wdata(wd_l), .i_we_upper(weu_l), .i_we_lower(wel_l), .o_rdata(rd_l));
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input string name, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  // One sampled edge with the given pins, then an idle edge so nothing is sampled twice
  task automatic step(input logic s, p, c, h, l, v, input logic [15:0] a, d, input logic [1:0] q);
    @(posedge i_sys_clk);
    {sel_n, pstb_n, cstb_n, wh_n, wl_n, step_n} <= {s, p, c, h, l, v};
    {addr, dq, dp} <= {a, d, q};
    @(posedge i_sys_clk);
    {sel_n, pstb_n, cstb_n, wh_n, wl_n, step_n} <= 6'h1F;
    #1;
  endtask
  task automatic t_ctrl_write();
    step(0, 1, 0, 1, 0, 1, 16'h1234, 16'hBEEF, 2'h1);
    chk("ctrl addr", 18'h01234, {2'h0, a_i});
    chk("ctrl wdata", 18'h1BEEF, wd_i);
    chk("ctrl we", 18'h00001, {weu, wel});
    chk("ctrl oe low", 18'h00000, {17'h0, oel});
    step(0, 1, 0, 1, 1, 1, 16'h1234, 16'h0000, 2'h0);
    @(posedge i_sys_clk);
    #1;
    chk("read lower", 18'h001EF, {9'h0, dpo_i[0], dqo_i[7:0]});
    chk("read lower lin", 18'h001EF, {9'h0, dpo_l[0], dqo_l[7:0]});
    chk("read drive", 18'h0000F, {14'h0, oeu_l, oel_l, oeu, oel});
  endtask
  task automatic t_proc_write();
    step(0, 0, 1, 0, 1, 1, 16'h4321, 16'h0000, 2'h0);
    chk("proc strobe we", 18'h00000, {weu, wel});
    step(0, 1, 1, 0, 1, 1, 16'hFFFF, 16'hA55A, 2'h2);
    chk("proc addr", 18'h04321, {2'h0, a_i});
    chk("proc we", 18'h00002, {weu, wel});
    chk("proc wdata", 18'h2A55A, wd_i);
    chk("proc oe low", 18'h00000, {17'h0, oeu});
    step(0, 0, 0, 1, 0, 1, 16'h0777, 16'h0000, 2'h0);
    chk("both strobes we", 18'h00000, {weu, wel});
  endtask
  task automatic t_burst();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      step(0, 0, 1, 1, 1, 0, {14'h2969, s}, 16'h0000, 2'h0);
      chk("load il", {2'h0, 14'h2969, s}, {2'h0, a_i});
      chk("load lin", {2'h0, 14'h2969, s}, {2'h0, a_l});
      for (int k = 1; k < 4; k++) begin
        step(0, 1, 1, 1, 1, 0, 16'h0000, 16'h0000, 2'h0);
        chk("step il", {2'h0, 14'h2969, s ^ 2'(k)}, {2'h0, a_i});
        chk("step lin", {2'h0, 14'h2969, 2'(s + 2'(k))}, {2'h0, a_l});
      end
    end
  endtask
  // Counter sits at start 3, step 3; cs high with processor strobe low must not load
  task automatic t_cs_high();
    step(1, 0, 1, 1, 0, 0, 16'h0000, 16'h00C3, 2'h1);
    chk("cs high il", 18'h0A5A7, {2'h0, a_i});
    chk("cs high lin", 18'h0A5A7, {2'h0, a_l});
    chk("cs high we", 18'h00001, {weu, wel});
    step(1, 1, 0, 1, 0, 1, 16'h0100, 16'h0000, 2'h0);
    chk("deselect we", 18'h00000, {weu, wel});
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_ctrl_write();
    t_proc_write();
    t_burst();
    t_cs_high();
    finish_test();
  end
endmodule // tb
